// *** hw/temp_alarm_pkg.sv ***
/*
 * Shared constants and carrier types for the temperature alarm and serial
 * register core. Assumes a 50 MHz reference clock and a host that drives the
 * serial clock as an open-drain bus master.
 */
package temp_alarm_pkg;

    // ****************************************
    // Timing
    // ****************************************
    localparam int unsigned CLK_HZ          = 50_000_000;
    localparam int unsigned CYCLES_PER_MS   = CLK_HZ / 1000;
    localparam int unsigned MEAS_MS         = 38;
    localparam int unsigned MEAS_CYCLES     = MEAS_MS * CYCLES_PER_MS;
    localparam int unsigned TIMEOUT_MS      = 35;
    localparam int unsigned TIMEOUT_CYCLES  = TIMEOUT_MS * CYCLES_PER_MS;
    localparam int          CONV_CNT_W      = 28;
    localparam int          TO_CNT_W        = 21;
    localparam logic [2:0]  RATE_MAX        = 3'h7;
    localparam logic [1:0]  QUEUE_LEN       = 2'h3;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] REG_LOCAL_READING  = 8'h00;
    localparam logic [7:0] REG_REMOTE_MSB     = 8'h01;
    localparam logic [7:0] REG_STATUS         = 8'h02;
    localparam logic [7:0] REG_RATE           = 8'h03;
    localparam logic [7:0] REG_LOCAL_UPPER    = 8'h04;
    localparam logic [7:0] REG_LOCAL_LOWER    = 8'h05;
    localparam logic [7:0] REG_REMOTE_UPPER   = 8'h06;
    localparam logic [7:0] REG_REMOTE_LOWER   = 8'h07;
    localparam logic [7:0] REG_REMOTE_CRIT    = 8'h08;
    localparam logic [7:0] REG_DEVICE_CONFIG  = 8'h09;
    localparam logic [7:0] REG_LOCAL_CRIT     = 8'h0A;
    localparam logic [7:0] REG_CRIT_HYST      = 8'h0B;
    localparam logic [7:0] REG_REMOTE_LSB     = 8'h0C;
    localparam logic [7:0] UNMAPPED_READ      = 8'hFF;

    localparam int CFG_QUEUE_BIT  = 0;
    localparam int CFG_MASK_BIT   = 7;
    localparam int STS_BUSY_BIT   = 7;
    localparam int STS_LHIGH_BIT  = 6;
    localparam int STS_LLOW_BIT   = 5;
    localparam int STS_RHIGH_BIT  = 4;
    localparam int STS_RLOW_BIT   = 3;
    localparam int STS_OPEN_BIT   = 2;
    localparam int STS_RCRIT_BIT  = 1;
    localparam int STS_LCRIT_BIT  = 0;

    localparam logic [7:0] CFG_RESET    = 8'h00;
    localparam logic [7:0] RATE_RESET   = 8'h02;
    localparam logic [7:0] UPPER_RESET  = 8'h46;
    localparam logic [7:0] LOWER_RESET  = 8'h00;
    localparam logic [7:0] CRIT_RESET   = 8'h55;
    localparam logic [7:0] HYST_RESET   = 8'h0A;
    localparam logic [7:0] OPEN_READING = 8'h7F;
    localparam logic [7:0] GND_READING  = 8'h80;
    localparam logic [7:0] ZERO_BYTE    = 8'h00;

    // ****************************************
    // Types
    // ****************************************
    typedef struct packed {
        logic [7:0] local_temp;
        logic [7:0] remote_msb;
        logic [7:0] remote_lsb;
        logic       diode_open;
        logic       diode_grounded;
    } conv_sample_t;

    typedef enum logic [3:0] {
        L_IDLE, L_ADDR, L_ADDR_ACK, L_CMD, L_CMD_ACK, L_DATA_W, L_DATA_W_ACK, L_TX, L_TX_ACK
    } link_state_t;

    typedef struct packed {
        link_state_t st;
        logic [2:0]  cnt;
        logic [7:0]  shift;
        logic [7:0]  tx;
        logic        rw;
        logic        drive;
        logic        hold;
        logic        ev_tog;
        logic        ev_wr;
        logic [7:0]  ev_ptr;
        logic [7:0]  ev_data;
        logic        start_seen;
        logic [1:0]  to_s;
        logic        to_seen;
        logic [1:0]  rst_s;
    } link_regs_t;

    typedef struct packed {
        logic [2:0]            sck_s;
        logic [2:0]            sda_s;
        logic [2:0]            ev_s;
        logic [2:0]            hold_s;
        logic                  scl_lvl;
        logic                  sda_lvl;
        logic                  hold_lvl;
        logic                  ev_last;
        logic [TO_CNT_W-1:0]   to_cnt;
        logic                  to_tog;
        logic                  release_bus;
        logic [CONV_CNT_W-1:0] conv_cnt;
        logic                  meas;
        logic                  eval;
        logic [7:0]            ptr;
        logic [7:0]            cfg;
        logic [7:0]            rate;
        logic [1:0][7:0]       hi;
        logic [1:0][7:0]       lo;
        logic [1:0][7:0]       crit;
        logic [7:0]            hyst;
        logic [1:0][7:0]       temp;
        logic [7:0]            rlsb;
        logic                  open;
        logic [1:0][1:0]       q_hi;
        logic [1:0][1:0]       q_lo;
        logic [1:0][1:0]       q_cr;
        logic [1:0][1:0]       q_cc;
        logic [1:0]            act_hi;
        logic [1:0]            act_lo;
        logic [1:0]            act_cr;
        logic [7:0]            shadow;
        logic                  alert_n;
        logic                  crit_n;
    } mon_regs_t;

endpackage : temp_alarm_pkg

// *** hw/temp_alarm_fault_queue_smbus.sv ***
/*
 * Alarm qualification, diode fault substitution, conversion sequencing and
 * the two-wire register slave of the temperature sensor.
 * Assumes the analog front end delivers samples on ref_clk and that the bus
 * clock is a host-driven clock that may stop outside transfers.
 */
`timescale 1ns/10ps
module temp_alarm_fault_queue_smbus
    import temp_alarm_pkg::*;
#(
    parameter int unsigned MEAS_CYCLES_P    = MEAS_CYCLES,
    parameter int unsigned TIMEOUT_CYCLES_P = TIMEOUT_CYCLES,
    parameter logic [6:0]  DEVICE_ADDRESS   = 7'h2A  // Arbitrary value
) (
    input  wire logic         ref_clk,
    input  wire logic         sys_rst,
    input  wire logic         serial_clock,
    input  wire logic         serial_data_in,
    output logic              serial_data_out,
    output logic              serial_data_oe,
    input  wire conv_sample_t sample,
    output logic              measure_active,
    output logic              alert_n,
    output logic              critical_overheat_n
);

    // ****************************************
    // Elaboration checks
    // ****************************************
    if (MEAS_CYCLES_P < 1 || (64'(MEAS_CYCLES_P) << RATE_MAX) >= (64'd1 << CONV_CNT_W)) begin : g_bad_meas
        $error("MEAS_CYCLES_P out of range");
    end
    if (TIMEOUT_CYCLES_P < 2 || 64'(TIMEOUT_CYCLES_P) >= (64'd1 << TO_CNT_W)) begin : g_bad_to
        $error("TIMEOUT_CYCLES_P out of range");
    end

    mon_regs_t  mon;
    mon_regs_t  next_mon;
    link_regs_t link;
    link_regs_t next_link;
    logic       sda_at_rise;
    logic       start_tog;

    // ****************************************
    // Per-channel limit compares
    // ****************************************
    logic [1:0] over_hi;
    logic [1:0] under_lo;
    logic [1:0] over_cr;
    logic [1:0] below_cc;

    for (genvar ch = 0; ch < 2; ch++) begin : g_cmp
        logic signed [9:0] cc_limit;
        assign cc_limit     = $signed({{2{mon.crit[ch][7]}}, mon.crit[ch]}) - $signed({2'b00, mon.hyst});
        assign over_hi[ch]  = $signed(mon.temp[ch]) > $signed(mon.hi[ch]);
        assign under_lo[ch] = $signed(mon.temp[ch]) < $signed(mon.lo[ch]);
        assign over_cr[ch]  = $signed(mon.temp[ch]) > $signed(mon.crit[ch]);
        assign below_cc[ch] = $signed({{2{mon.temp[ch][7]}}, mon.temp[ch]}) < cc_limit;
    end

    function automatic logic [1:0] sat_inc(input logic [1:0] q);
        sat_inc = (q == QUEUE_LEN) ? QUEUE_LEN : q + 2'd1;
    endfunction

    // ****************************************
    // Reference clock domain
    // ****************************************
    always_comb begin
        logic [1:0]            need;
        logic [7:0]            rd;
        logic [CONV_CNT_W-1:0] period;
        logic [CONV_CNT_W-1:0] cnt_next;
        need     = 2'd0;
        rd       = 8'h00;
        period   = '0;
        cnt_next = '0;
        next_mon = mon;

        // Pins and link flags: three flops, a change counts when the last two agree
        next_mon.sck_s  = {mon.sck_s[1:0], serial_clock};
        next_mon.sda_s  = {mon.sda_s[1:0], serial_data_in};
        next_mon.ev_s   = {mon.ev_s[1:0], link.ev_tog};
        next_mon.hold_s = {mon.hold_s[1:0], link.hold};
        if (mon.sck_s[1] == mon.sck_s[2]) begin
            next_mon.scl_lvl = mon.sck_s[2];
        end
        if (mon.sda_s[1] == mon.sda_s[2]) begin
            next_mon.sda_lvl = mon.sda_s[2];
        end
        if (mon.hold_s[1] == mon.hold_s[2]) begin
            next_mon.hold_lvl = mon.hold_s[2];
        end

        // Bus time-out: output is gated here because the link clock is stopped
        if (!mon.scl_lvl && !mon.sda_lvl) begin
            if (mon.to_cnt != TO_CNT_W'(TIMEOUT_CYCLES_P)) begin
                next_mon.to_cnt = mon.to_cnt + 1'b1;
            end
            if (mon.to_cnt == TO_CNT_W'(TIMEOUT_CYCLES_P - 1)) begin
                next_mon.to_tog      = ~mon.to_tog;
                next_mon.release_bus = 1'b1;
            end
        end else begin
            next_mon.to_cnt = '0;
        end
        if (mon.scl_lvl && mon.sda_lvl) begin
            next_mon.release_bus = 1'b0;
        end

        // Register writes and pointer updates from the link
        if (mon.ev_s[1] == mon.ev_s[2] && mon.ev_s[2] != mon.ev_last) begin
            next_mon.ev_last = mon.ev_s[2];
            next_mon.ptr     = link.ev_ptr;
            if (link.ev_wr) begin
                unique case (link.ev_ptr)
                    REG_RATE:          next_mon.rate    = (link.ev_data > {5'h00, RATE_MAX}) ?
                                                          {5'h00, RATE_MAX} : link.ev_data;
                    REG_DEVICE_CONFIG: next_mon.cfg     = link.ev_data;
                    REG_LOCAL_UPPER:   next_mon.hi[0]   = link.ev_data;
                    REG_LOCAL_LOWER:   next_mon.lo[0]   = link.ev_data;
                    REG_REMOTE_UPPER:  next_mon.hi[1]   = link.ev_data;
                    REG_REMOTE_LOWER:  next_mon.lo[1]   = link.ev_data;
                    REG_REMOTE_CRIT:   next_mon.crit[1] = link.ev_data;
                    REG_LOCAL_CRIT:    next_mon.crit[0] = link.ev_data;
                    REG_CRIT_HYST:     next_mon.hyst    = link.ev_data;
                    default: ;
                endcase
            end
        end

        // Conversion sequencing
        period   = CONV_CNT_W'(MEAS_CYCLES_P) << mon.rate[2:0];
        cnt_next = (mon.conv_cnt >= period - 1'b1) ? '0 : mon.conv_cnt + 1'b1;
        next_mon.conv_cnt = cnt_next;
        next_mon.meas     = cnt_next < CONV_CNT_W'(MEAS_CYCLES_P);
        next_mon.eval     = 1'b0;
        if (mon.conv_cnt == CONV_CNT_W'(MEAS_CYCLES_P - 1)) begin
            next_mon.eval    = 1'b1;
            next_mon.temp[0] = sample.local_temp;
            next_mon.open    = sample.diode_open;
            if (sample.diode_open) begin
                next_mon.temp[1] = OPEN_READING;
                next_mon.rlsb    = ZERO_BYTE;
            end else if (sample.diode_grounded) begin
                next_mon.temp[1] = GND_READING;
                next_mon.rlsb    = ZERO_BYTE;
            end else begin
                next_mon.temp[1] = sample.remote_msb;
                next_mon.rlsb    = sample.remote_lsb;
            end
        end

        // Alarm qualification, one conversion at a time
        need = mon.cfg[CFG_QUEUE_BIT] ? QUEUE_LEN : 2'd1;
        if (mon.eval) begin
            for (int ch = 0; ch < 2; ch++) begin
                next_mon.q_hi[ch]   = over_hi[ch] ? sat_inc(mon.q_hi[ch]) : 2'd0;
                next_mon.q_lo[ch]   = under_lo[ch] ? sat_inc(mon.q_lo[ch]) : 2'd0;
                next_mon.q_cr[ch]   = over_cr[ch] ? sat_inc(mon.q_cr[ch]) : 2'd0;
                next_mon.q_cc[ch]   = below_cc[ch] ? sat_inc(mon.q_cc[ch]) : 2'd0;
                next_mon.act_hi[ch] = over_hi[ch] && (next_mon.q_hi[ch] >= need);
                next_mon.act_lo[ch] = under_lo[ch] && (next_mon.q_lo[ch] >= need);
                if (!mon.act_cr[ch] && next_mon.q_cr[ch] >= need) begin
                    next_mon.act_cr[ch] = 1'b1;
                end else if (mon.act_cr[ch] && next_mon.q_cc[ch] >= need) begin
                    next_mon.act_cr[ch] = 1'b0;
                end
            end
        end

        // Open flag is not an alarm source; only the compares are
        next_mon.alert_n = ~((|(mon.act_hi | mon.act_lo)) & ~mon.cfg[CFG_MASK_BIT]);
        next_mon.crit_n  = ~(|mon.act_cr);

        // Read view, frozen while the link shifts it out
        unique case (mon.ptr)
            REG_LOCAL_READING: rd = mon.temp[0];
            REG_REMOTE_MSB:    rd = mon.temp[1];
            REG_REMOTE_LSB:    rd = mon.rlsb;
            REG_RATE:          rd = mon.rate;
            REG_LOCAL_UPPER:   rd = mon.hi[0];
            REG_LOCAL_LOWER:   rd = mon.lo[0];
            REG_REMOTE_UPPER:  rd = mon.hi[1];
            REG_REMOTE_LOWER:  rd = mon.lo[1];
            REG_REMOTE_CRIT:   rd = mon.crit[1];
            REG_LOCAL_CRIT:    rd = mon.crit[0];
            REG_CRIT_HYST:     rd = mon.hyst;
            REG_DEVICE_CONFIG: rd = mon.cfg;
            REG_STATUS: begin
                rd[STS_BUSY_BIT]  = mon.meas;
                rd[STS_LHIGH_BIT] = mon.act_hi[0];
                rd[STS_LLOW_BIT]  = mon.act_lo[0];
                rd[STS_RHIGH_BIT] = mon.act_hi[1];
                rd[STS_RLOW_BIT]  = mon.act_lo[1];
                rd[STS_OPEN_BIT]  = mon.open;
                rd[STS_RCRIT_BIT] = mon.act_cr[1];
                rd[STS_LCRIT_BIT] = mon.act_cr[0];
            end
            default:           rd = UNMAPPED_READ;
        endcase
        if (!mon.hold_lvl) begin
            next_mon.shadow = rd;
        end

        if (sys_rst) begin
            next_mon             = '0;
            next_mon.release_bus = 1'b1;
            next_mon.cfg         = CFG_RESET;
            next_mon.rate        = RATE_RESET;
            next_mon.hi          = {UPPER_RESET, UPPER_RESET};
            next_mon.lo          = {LOWER_RESET, LOWER_RESET};
            next_mon.crit        = {CRIT_RESET, CRIT_RESET};
            next_mon.hyst        = HYST_RESET;
            next_mon.alert_n     = 1'b1;
            next_mon.crit_n      = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        mon <= next_mon;
    end

    // ****************************************
    // Link clock domain
    // ****************************************
    // START is seen by the data line falling with the clock high; the pending
    // mark is held until the link consumes it at the next clock fall.
    always_ff @(negedge serial_data_in or posedge sys_rst) begin
        if (sys_rst) begin
            start_tog <= 1'b0;
        end else if (serial_clock) begin
            start_tog <= ~link.start_seen;
        end
    end

    always_ff @(posedge serial_clock) begin
        sda_at_rise <= serial_data_in;
    end

    always_comb begin
        next_link       = link;
        next_link.rst_s = {link.rst_s[0], sys_rst};
        next_link.to_s  = {link.to_s[0], mon.to_tog};
        if (link.rst_s[1]) begin
            next_link       = '0;
            next_link.rst_s = {link.rst_s[0], sys_rst};
        end else if (link.to_s[1] != link.to_seen) begin
            next_link.to_seen = link.to_s[1];
            next_link.st      = L_IDLE;
            next_link.drive   = 1'b0;
            next_link.hold    = 1'b0;
        end else if (start_tog != link.start_seen) begin
            next_link.start_seen = start_tog;
            next_link.st         = L_ADDR;
            next_link.cnt        = 3'd0;
            next_link.drive      = 1'b0;
            next_link.hold       = 1'b0;
        end else begin
            unique case (link.st)
                L_IDLE: ;
                L_ADDR: begin
                    next_link.shift = {link.shift[6:0], sda_at_rise};
                    next_link.cnt   = link.cnt + 3'd1;
                    if (link.cnt == 3'd7) begin
                        if (link.shift[6:0] == DEVICE_ADDRESS) begin
                            next_link.rw    = sda_at_rise;
                            next_link.hold  = sda_at_rise;
                            next_link.drive = 1'b1;
                            next_link.st    = L_ADDR_ACK;
                        end else begin
                            next_link.st = L_IDLE;
                        end
                    end
                end
                L_ADDR_ACK: begin
                    next_link.cnt = 3'd0;
                    if (link.rw) begin
                        next_link.tx    = mon.shadow;
                        next_link.drive = ~mon.shadow[7];
                        next_link.st    = L_TX;
                    end else begin
                        next_link.drive = 1'b0;
                        next_link.st    = L_CMD;
                    end
                end
                L_CMD: begin
                    next_link.shift = {link.shift[6:0], sda_at_rise};
                    next_link.cnt   = link.cnt + 3'd1;
                    if (link.cnt == 3'd7) begin
                        next_link.ev_ptr = {link.shift[6:0], sda_at_rise};
                        next_link.drive  = 1'b1;
                        next_link.st     = L_CMD_ACK;
                    end
                end
                L_CMD_ACK: begin
                    next_link.drive  = 1'b0;
                    next_link.cnt    = 3'd0;
                    next_link.ev_wr  = 1'b0;
                    next_link.ev_tog = ~link.ev_tog;
                    next_link.st     = L_DATA_W;
                end
                L_DATA_W: begin
                    next_link.shift = {link.shift[6:0], sda_at_rise};
                    next_link.cnt   = link.cnt + 3'd1;
                    if (link.cnt == 3'd7) begin
                        next_link.ev_data = {link.shift[6:0], sda_at_rise};
                        next_link.drive   = 1'b1;
                        next_link.st      = L_DATA_W_ACK;
                    end
                end
                L_DATA_W_ACK: begin
                    next_link.drive  = 1'b0;
                    next_link.ev_wr  = 1'b1;
                    next_link.ev_tog = ~link.ev_tog;
                    next_link.st     = L_IDLE;
                end
                L_TX: begin
                    next_link.cnt = link.cnt + 3'd1;
                    next_link.tx  = {link.tx[6:0], 1'b0};
                    if (link.cnt == 3'd7) begin
                        next_link.drive = 1'b0;
                        next_link.st    = L_TX_ACK;
                    end else begin
                        next_link.drive = ~link.tx[6];
                    end
                end
                L_TX_ACK: begin
                    next_link.hold = 1'b0;
                    next_link.st   = L_IDLE;
                end
            endcase
        end
    end

    // Reset acts at once: the link clock is usually stopped while reset is high
    always_ff @(negedge serial_clock or posedge sys_rst) begin
        if (sys_rst) begin
            link <= '0;
        end else begin
            link <= next_link;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    // Open-drain: only ever pulls low; time-out release overrides the link
    assign serial_data_out     = 1'b0;
    assign serial_data_oe      = link.drive & ~mon.release_bus;
    assign measure_active      = mon.meas;
    assign alert_n             = mon.alert_n;
    assign critical_overheat_n = mon.crit_n;

endmodule // temp_alarm_fault_queue_smbus

// *** tb/temp_alarm_assertions.sv ***
/* Port checker for the alarm core. Assumes a bind into its top, ref_clk domain. */
`timescale 1ns/10ps
module temp_alarm_assertions #(parameter int unsigned TO = 50) (input wire logic ref_clk, sys_rst,
    serial_clock, serial_data_oe, measure_active, alert_n, critical_overheat_n);
    logic [15:0] drv;
    // Counts clock-low cycles with the data pin pulled
    always_ff @(posedge ref_clk) drv <= (sys_rst || serial_clock || !serial_data_oe) ? '0 : drv + 16'h0001;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    sequence s_meas; measure_active [*8]; endsequence
    sequence s_quiet(sig); $stable(sig) [*8]; endsequence
    property p_oe_edge; $changed(serial_data_oe) |-> !serial_clock; endproperty
    a_oe_edge: assert property (p_oe_edge) else $error("data moved, clock high");
    property p_timeout; serial_data_oe && !serial_clock |-> drv <= TO + 8; endproperty
    a_timeout: assert property (p_timeout) else $error("bus held past limit");
    property p_meas; $rose(measure_active) |-> s_meas; endproperty
    a_meas: assert property (p_meas) else $error("short measurement");
    property p_a_when; $changed(alert_n) |-> !measure_active; endproperty
    a_a_when: assert property (p_a_when) else $error("alert mid-measure");
    property p_c_when; $changed(critical_overheat_n) |-> !measure_active; endproperty
    a_c_when: assert property (p_c_when) else $error("critical mid-measure");
    property p_a_hold; $changed(alert_n) |=> s_quiet(alert_n); endproperty
    a_a_hold: assert property (p_a_hold) else $error("alert bounce");
    property p_c_hold; $changed(critical_overheat_n) |=> s_quiet(critical_overheat_n); endproperty
    a_c_hold: assert property (p_c_hold) else $error("critical bounce");
    property p_c_meas; $fell(critical_overheat_n) |-> !measure_active ##1 !measure_active; endproperty
    a_c_meas: assert property (p_c_meas) else $error("critical early");
endmodule // temp_alarm_assertions
bind temp_alarm_fault_queue_smbus temp_alarm_assertions #(.TO(TIMEOUT_CYCLES_P)) i_temp_alarm_assertions (.ref_clk,
    .sys_rst, .serial_clock, .serial_data_oe, .measure_active, .alert_n, .critical_overheat_n);

// *** tb/smbus_host_model.sv ***
/* Two-wire host model. Assumes a pull-up: the wire is resolved by the bench. */
`timescale 1ns/10ps
module smbus_host_model (output logic scl, pull, input wire logic sda);
    logic [7:0] got = 8'h00;
    event seen;
    initial {scl, pull} = 2'b10;
    task automatic bt(input logic b, output logic r); pull = !b; #16 scl = 1; #16 r = sda; #16 scl = 0; #16; endtask
    task automatic xf(input logic [7:0] d, output logic [7:0] q, output logic n);
        for (int i = 7; i >= 0; i--) bt(d[i], q[i]);
        bt(1, n);
    endtask
    task automatic st; pull = 0; #16 scl = 1; #16 pull = 1; #16 scl = 0; #16; endtask
    task automatic sp; pull = 1; #16 scl = 1; #16 pull = 0; #32; endtask
    task automatic op(input int k, input logic [6:0] a, input logic [7:0] c, d, output logic n);
        logic [7:0] t;
        logic x;
        n = 0;
        st;
        if (k != 3) begin xf({a, 1'b0}, t, x); n |= x; xf(c, t, x); n |= x; end
        if (k == 0) begin xf(d, t, x); n |= x; end
        if (k > 1) begin if (k == 2) st; xf({a, 1'b1}, t, x); n |= x; xf(8'hFF, got, x); if (!n) -> seen; end
        sp;
    endtask
    // Stalls the clock low mid-read so the slave must give up the bus
    task automatic hang(input logic [6:0] a); logic [7:0] t; logic x; st; xf({a, 1'b1}, t, x); #2000; endtask
    // Clocks the stalled slave back to idle, then rests the bus high
    task automatic rec; logic r; repeat (3) bt(1, r); sp; #200; endtask
endmodule // smbus_host_model

// *** tb/temp_alarm_fault_queue_smbus_tb.sv ***
/* Self-checking bench. Assumes short count parameters and the host model. */
`timescale 1ns/10ps
module temp_alarm_fault_queue_smbus_tb;
    import temp_alarm_pkg::*;
    localparam logic [6:0] ADR = 7'h2A;
    logic ref_clk = 0, sys_rst, scl, pull, sdo, oe, meas, alert_n, crit_n;
    conv_sample_t smp = '0;
    logic [16:0] lfsr = 17'h15234;
    logic [7:0] exp_q[$];
    int failures = 0, check_count = 0, cyc = 0;
    wire sda = !(pull | oe);
    always #10 ref_clk = ~ref_clk;
    smbus_host_model i_smbus_host_model (.scl, .pull, .sda);
    temp_alarm_fault_queue_smbus #(.MEAS_CYCLES_P(20), .TIMEOUT_CYCLES_P(50)) i_temp_alarm_fault_queue_smbus (.ref_clk,
        .sys_rst, .serial_clock(scl), .serial_data_in(sda), .serial_data_out(sdo), .serial_data_oe(oe),
        .sample(smp), .measure_active(meas), .alert_n, .critical_overheat_n(crit_n));
    function automatic logic [16:0] nx(input logic [16:0] v); return {v[15:0], v[16] ^ v[13]}; endfunction
    task automatic check(input string w, input logic [7:0] s, e);
        check_count++;
        if (s !== e) begin failures++; $display("[FAIL] %s exp %h got %h", w, e, s); end
    endtask
    task automatic conclude;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge ref_clk) if (++cyc > 20000) begin failures++; conclude; end
    always @(i_smbus_host_model.seen) check("read", i_smbus_host_model.got, exp_q.pop_front());
    task automatic op(input int k, input logic [7:0] c, d, input logic [6:0] a = ADR);
        logic n;
        if (k > 1 && a == ADR) exp_q.push_back(d);
        i_smbus_host_model.op(k, a, c, d, n);
        check("ack", 8'(n), 8'(a != ADR));
    endtask
    // Holds one sample for k conversions, then looks at both alarms
    task automatic cv(input logic [7:0] lc, rm, input logic [1:0] fl, input int k, input logic ea, ec);
        @(negedge ref_clk);
        lfsr = nx(lfsr);
        smp = '{lc | 8'(lfsr[12:8]), rm, lfsr[7:0], fl[1], fl[0]};
        repeat (k) @(negedge meas);
        repeat (3) @(negedge ref_clk);
        check("alert", 8'(alert_n), 8'(ea));
        check("crit", 8'(crit_n), 8'(ec));
    endtask
    initial begin
        // Reset rises after time zero so the link sees a reset edge
        #1 sys_rst = 1;
        repeat (2) @(negedge ref_clk);
        sys_rst = 0;
        repeat (8) @(negedge ref_clk);
        check("alert", 8'(alert_n), 8'h01);
        op(2, REG_DEVICE_CONFIG, CFG_RESET);
        cv(8'h20, 8'h50, 0, 1, 0, 1);
        cv(8'h20, 8'h30, 0, 1, 1, 1);
        op(0, REG_DEVICE_CONFIG, 8'h01);
        op(3, 0, 8'h01);
        cv(8'h20, 8'h50, 0, 2, 1, 1);
        cv(8'h20, 8'h30, 0, 1, 1, 1);
        cv(8'h20, 8'h50, 0, 3, 0, 1);
        cv(8'h20, 8'h30, 0, 1, 1, 1);
        cv(8'h20, 8'h60, 0, 3, 0, 0);
        cv(8'h20, 8'h40, 0, 2, 1, 0);
        cv(8'h20, 8'h40, 0, 1, 1, 1);
        cv(8'h20, 8'hF0, 0, 2, 1, 1);
        cv(8'h20, 8'hF0, 0, 1, 0, 1);
        cv(8'h50, 8'h10, 0, 2, 1, 1);
        cv(8'h20, 8'h50, 0, 1, 1, 1);
        $display("queue test done");
        cv(8'h20, 8'h30, 2, 3, 0, 0);
        op(2, REG_REMOTE_MSB, OPEN_READING);
        op(2, REG_REMOTE_LSB, ZERO_BYTE);
        op(0, REG_DEVICE_CONFIG, 8'h81);
        cv(8'h20, 8'h30, 2, 1, 1, 0);
        op(0, REG_DEVICE_CONFIG, 8'h01);
        op(0, REG_REMOTE_UPPER, 8'h7F);
        cv(8'h20, 8'h30, 2, 1, 1, 0);
        cv(8'h20, 8'h30, 1, 3, 0, 1);
        op(1, REG_REMOTE_MSB, 0);
        op(3, 0, GND_READING);
        op(0, REG_DEVICE_CONFIG, 0, 7'h2B);
        op(2, 8'h3F, UNMAPPED_READ);
        $display("fault test done");
        op(2, REG_DEVICE_CONFIG, 8'h01);
        i_smbus_host_model.hang(ADR);
        check("release", 8'(oe), 8'h00);
        i_smbus_host_model.rec;
        op(3, 0, 8'h01);
        check("pending", 8'(exp_q.size()), 8'h00);
        check("sdo", 8'(sdo), 8'h00);
        $display("bus test done");
        conclude;
    end
endmodule // temp_alarm_fault_queue_smbus_tb
